// ==== rtl/lamp_osc_emi_control.sv ====
// lamp oscillator emi control register with spread and step decode
//
// Functional notes
// - emi setup is an eight-bit register at F6h, shadowed from nv memory, zero by default.
// - bits 1:0 pick spread depth: off, 1.5, 3.0 or 6.0 percent either side of nominal.
// - step enable bit 4 ORed with the step pin; one applies the step, zero keeps nominal.
// - the step acts only when both depth bits are zero; it is suppressed while spreading.
// - spreading on, bits 7:5 pick the modulation rate, lamp frequency times 4 down to 1/16.
`default_nettype none
module lamp_osc_emi_control (
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_SRST,
  input  wire logic [7:0] I_REG_ADDR,
  input  wire logic       I_REG_WR,
  input  wire logic       I_REG_RD,
  input  wire logic [7:0] I_REG_WDATA,
  input  wire logic       I_NV_LOAD,
  input  wire logic [7:0] I_NV_DATA,
  input  wire logic       I_STEP_PIN,
  output logic [7:0]      O_REG_RDATA,
  output logic            O_REG_RVALID,
  output logic            O_NV_WR_REQ,
  output logic [7:0]      O_NV_WR_DATA,
  output logic [1:0]      O_SPREAD_DEPTH,
  output logic [7:0]      O_SPREAD_TENTHS,
  output logic            O_SPREAD_ACTIVE,
  output logic            O_SPREAD_WAVEFORM,
  output logic [2:0]      O_MOD_RATE_SEL,
  output logic [3:0]      O_MOD_RATE_LOG2,
  output logic            O_STEP_INVOKED,
  output logic            O_STEP_ACTIVE,
  output logic            O_STEP_UP,
  output logic [2:0]      O_STEP_PERCENT
);
  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rdata;
    logic       rvalid;
    logic       nv_wr_req;
    logic [7:0] nv_wr_data;
    logic [1:0] spread_depth;
    logic [7:0] spread_tenths;
    logic       spread_active;
    logic       spread_waveform;
    logic [2:0] mod_rate_sel;
    logic [3:0] mod_rate_log2;
    logic       step_invoked;
    logic       step_active;
    logic       step_up;
    logic [2:0] step_percent;
  } emi_state_type;

  emi_state_type state_reg;
  emi_state_type state_next;

  logic       step_pin_sync;
  logic       hit;
  logic [7:0] ctrl_new;
  logic [1:0] depth;
  logic [2:0] sel;
  logic [2:0] sel_clamped;
  logic       spreading;
  logic       invoked;

  // ==========================================================================
  // external step pin crossing
  step_pin_sync u_step_pin_sync (
    .i_clk   (I_SYS_CLK),
    .i_srst  (I_SRST),
    .i_async (I_STEP_PIN),
    .o_sync  (step_pin_sync)
  );

  // ==========================================================================
  // register access and decode
  always_comb begin
    state_next = state_reg;
    hit        = (I_REG_ADDR == lamp_emi_pkg::EMI_CTRL_ADDR);
    ctrl_new   = state_reg.ctrl;
    // a bus write beats a shadow reload in the same cycle
    if (I_NV_LOAD) begin
      ctrl_new = I_NV_DATA & lamp_emi_pkg::EMI_CTRL_WMASK;
    end
    if (I_REG_WR && hit) begin
      ctrl_new = I_REG_WDATA & lamp_emi_pkg::EMI_CTRL_WMASK;
    end
    state_next.ctrl       = ctrl_new;
    // keep the nv copy in step with every accepted write
    state_next.nv_wr_req  = I_REG_WR && hit;
    state_next.nv_wr_data = I_REG_WR && hit ?
                            (I_REG_WDATA & lamp_emi_pkg::EMI_CTRL_WMASK) : 8'h00;
    state_next.rvalid     = I_REG_RD;
    state_next.rdata      = (I_REG_RD && hit) ? state_reg.ctrl
                                              : lamp_emi_pkg::UNMAPPED_RDATA;

    // decode from the value being stored so outputs update on the same edge as the register
    depth = ctrl_new[lamp_emi_pkg::SPREAD_DEPTH_MSB_POS:lamp_emi_pkg::SPREAD_DEPTH_LSB_POS];
    sel   = ctrl_new[lamp_emi_pkg::STEP_RATE_SEL_BIT2_POS:lamp_emi_pkg::STEP_RATE_SEL_BIT0_POS];
    // code 7 is undefined; it behaves as code 6 for the rate and gives no step
    sel_clamped = (sel > lamp_emi_pkg::STEP_CODE_LAST) ? lamp_emi_pkg::STEP_CODE_LAST : sel;
    spreading   = (depth != lamp_emi_pkg::SPREAD_OFF);
    invoked     = ctrl_new[lamp_emi_pkg::FREQ_STEP_ENABLE_POS] | step_pin_sync;

    state_next.spread_depth  = depth;
    state_next.spread_active = spreading;
    unique case (depth)
      lamp_emi_pkg::SPREAD_OFF: state_next.spread_tenths = lamp_emi_pkg::TENTHS_OFF;
      lamp_emi_pkg::SPREAD_1P5: state_next.spread_tenths = lamp_emi_pkg::TENTHS_1P5;
      lamp_emi_pkg::SPREAD_3P0: state_next.spread_tenths = lamp_emi_pkg::TENTHS_3P0;
      lamp_emi_pkg::SPREAD_6P0: state_next.spread_tenths = lamp_emi_pkg::TENTHS_6P0;
    endcase
    // waveform only matters while spreading; triangle otherwise
    state_next.spread_waveform = spreading ?
                                 ctrl_new[lamp_emi_pkg::SPREAD_WAVEFORM_SELECT_POS]
                                 : lamp_emi_pkg::WAVE_TRIANGLE;

    // rate: log2 of multiplier is 2 minus the code, from x4 to x1/16
    state_next.mod_rate_sel  = spreading ? sel_clamped : 3'h0;
    state_next.mod_rate_log2 = spreading ?
                               (lamp_emi_pkg::RATE_LOG2_TOP - {1'b0, sel_clamped})
                               : 4'h0;

    state_next.step_invoked = invoked;
    state_next.step_active  = invoked && !spreading
                              && (sel <= lamp_emi_pkg::STEP_CODE_LAST);
    if (invoked && !spreading && sel < lamp_emi_pkg::STEP_DOWN_FIRST) begin
      state_next.step_up      = 1'b1;
      state_next.step_percent = sel + lamp_emi_pkg::STEP_PCT_BASE;
    end else if (invoked && !spreading && sel <= lamp_emi_pkg::STEP_CODE_LAST) begin
      state_next.step_up      = 1'b0;
      state_next.step_percent = sel - lamp_emi_pkg::STEP_DOWN_FIRST
                                + lamp_emi_pkg::STEP_PCT_BASE;
    end else begin
      state_next.step_up      = 1'b0;
      state_next.step_percent = 3'h0;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      state_reg      <= '0;
      state_reg.ctrl <= lamp_emi_pkg::EMI_CTRL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // outputs
  assign O_REG_RDATA       = state_reg.rdata;
  assign O_REG_RVALID      = state_reg.rvalid;
  assign O_NV_WR_REQ       = state_reg.nv_wr_req;
  assign O_NV_WR_DATA      = state_reg.nv_wr_data;
  assign O_SPREAD_DEPTH    = state_reg.spread_depth;
  assign O_SPREAD_TENTHS   = state_reg.spread_tenths;
  assign O_SPREAD_ACTIVE   = state_reg.spread_active;
  assign O_SPREAD_WAVEFORM = state_reg.spread_waveform;
  assign O_MOD_RATE_SEL    = state_reg.mod_rate_sel;
  assign O_MOD_RATE_LOG2   = state_reg.mod_rate_log2;
  assign O_STEP_INVOKED    = state_reg.step_invoked;
  assign O_STEP_ACTIVE     = state_reg.step_active;
  assign O_STEP_UP         = state_reg.step_up;
  assign O_STEP_PERCENT    = state_reg.step_percent;
endmodule
`default_nettype wire

// ==== rtl/lamp_emi_pkg.sv ====
// constants and field layout of the lamp oscillator emi control register
`default_nettype none
package lamp_emi_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0] EMI_CTRL_ADDR   = 8'hF6;
  localparam logic [7:0] EMI_CTRL_RESET  = 8'h00;
  localparam logic [7:0] EMI_CTRL_WMASK  = 8'hF7;
  localparam logic [7:0] UNMAPPED_RDATA  = 8'h00;
  // ==========================================================================
  // field positions
  localparam int SPREAD_DEPTH_LSB_POS       = 0;
  localparam int SPREAD_DEPTH_MSB_POS       = 1;
  localparam int SPREAD_WAVEFORM_SELECT_POS = 2;
  localparam int FREQ_STEP_ENABLE_POS       = 4;
  localparam int STEP_RATE_SEL_BIT0_POS     = 5;
  localparam int STEP_RATE_SEL_BIT2_POS     = 7;
  // ==========================================================================
  // spread depth codes and their swing in tenths of a percent
  localparam logic [1:0] SPREAD_OFF   = 2'h0;
  localparam logic [1:0] SPREAD_1P5   = 2'h1;
  localparam logic [1:0] SPREAD_3P0   = 2'h2;
  localparam logic [1:0] SPREAD_6P0   = 2'h3;
  localparam logic [7:0] TENTHS_OFF   = 8'h00;
  localparam logic [7:0] TENTHS_1P5   = 8'h0F;
  localparam logic [7:0] TENTHS_3P0   = 8'h1E;
  localparam logic [7:0] TENTHS_6P0   = 8'h3C;
  // ==========================================================================
  // step and rate field codes
  localparam logic [2:0] STEP_DOWN_FIRST = 3'h4;
  localparam logic [2:0] STEP_CODE_LAST  = 3'h6;
  localparam logic [2:0] STEP_PCT_BASE   = 3'h1;
  localparam logic [3:0] RATE_LOG2_TOP   = 4'h2;
  localparam logic       WAVE_TRIANGLE   = 1'b0;
endpackage
`default_nettype wire

// ==== rtl/step_pin_sync.sv ====
// two-stage synchroniser for the external step input pin
`default_nettype none
module step_pin_sync (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_async,
  output logic      o_sync
);
  // ==========================================================================
  // state
  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_type;

  sync_state_type state_reg;
  sync_state_type state_next;

  // first stage feeds only the second stage
  always_comb begin
    state_next.meta   = i_async;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_sync = state_reg.stable;
endmodule
`default_nettype wire

// ==== test/lamp_osc_emi_control_monitor.sv ====
// checker for the lamp emi control register outputs
`default_nettype none
module lamp_emi_checker (
  input wire logic       I_SYS_CLK,
  input wire logic       I_SRST,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic       I_REG_WR,
  input wire logic       I_REG_RD,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic       O_REG_RVALID,
  input wire logic       O_NV_WR_REQ,
  input wire logic [1:0] O_SPREAD_DEPTH,
  input wire logic [7:0] O_SPREAD_TENTHS,
  input wire logic       O_SPREAD_ACTIVE,
  input wire logic       O_SPREAD_WAVEFORM,
  input wire logic [2:0] O_MOD_RATE_SEL,
  input wire logic       O_STEP_INVOKED,
  input wire logic       O_STEP_ACTIVE
);
  // ====
  // properties
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);
  wire logic wr_hit = I_REG_WR && (I_REG_ADDR == 8'hF6);
  property p_rvalid; I_REG_RD |=> O_REG_RVALID; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_nv_req; wr_hit |=> O_NV_WR_REQ; endproperty
  a_nv_req: assert property (p_nv_req) else $error("no write-back");
  property p_nv_idle; !I_REG_WR |=> !O_NV_WR_REQ; endproperty
  a_nv_idle: assert property (p_nv_idle) else $error("stray write-back");
  property p_depth;
    wr_hit |=> {6'h00, O_SPREAD_DEPTH} == ($past(I_REG_WDATA) & 8'h03);
  endproperty
  a_depth: assert property (p_depth) else $error("depth not stored");
  property p_active; O_SPREAD_ACTIVE == (O_SPREAD_DEPTH != 2'h0); endproperty
  a_active: assert property (p_active) else $error("active flag wrong");
  property p_tenths;
    O_SPREAD_TENTHS == ((O_SPREAD_DEPTH == 2'h0) ? 8'h00 : 8'h0F << (O_SPREAD_DEPTH - 2'h1));
  endproperty
  a_tenths: assert property (p_tenths) else $error("spread swing wrong");
  property p_quiet; O_SPREAD_ACTIVE |-> !O_STEP_ACTIVE; endproperty
  a_quiet: assert property (p_quiet) else $error("step while spreading");
  property p_wave; !O_SPREAD_ACTIVE |-> !O_SPREAD_WAVEFORM && O_MOD_RATE_SEL == 3'h0; endproperty
  a_wave: assert property (p_wave) else $error("spread fields leak");
  property p_invoke; wr_hit && I_REG_WDATA[4] |=> O_STEP_INVOKED; endproperty
  a_invoke: assert property (p_invoke) else $error("step not invoked");
  property p_rate;
    wr_hit && I_REG_WDATA[1:0] != 2'h0 && I_REG_WDATA[7:5] != 3'h7
      |=> {5'h00, O_MOD_RATE_SEL} == ($past(I_REG_WDATA) >> 5);
  endproperty
  a_rate: assert property (p_rate) else $error("rate select wrong");
endmodule
bind lamp_osc_emi_control lamp_emi_checker u_chk (.I_SYS_CLK, .I_SRST, .I_REG_ADDR,
  .I_REG_WR, .I_REG_RD, .I_REG_WDATA, .O_REG_RVALID, .O_NV_WR_REQ, .O_SPREAD_DEPTH,
  .O_SPREAD_TENTHS, .O_SPREAD_ACTIVE, .O_SPREAD_WAVEFORM, .O_MOD_RATE_SEL,
  .O_STEP_INVOKED, .O_STEP_ACTIVE);
`default_nettype wire

// ==== test/lamp_osc_emi_control_tb_top.sv ====
// self-checking bench for the lamp emi control register
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module lamp_osc_emi_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       nv_load = 1'b0;
  logic       pin = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] nv_data = 8'h00;
  logic [7:0] rdata, nv_wd, tenths;
  logic [1:0] depth;
  logic [2:0] rsel, pct;
  logic [3:0] rlog;
  logic       rvalid, nv_req, sp_act, wave, inv, st_act, up;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  // rate log2 per code: x4 halving down to x1/16, code 7 held at x1/16
  localparam logic [31:0] RATE_LOG2_EXP = 32'hCCDEF012;
  lamp_osc_emi_control uut (.I_SYS_CLK(clk), .I_SRST(srst), .I_REG_ADDR(addr),
    .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata), .I_NV_LOAD(nv_load),
    .I_NV_DATA(nv_data), .I_STEP_PIN(pin), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
    .O_NV_WR_REQ(nv_req), .O_NV_WR_DATA(nv_wd), .O_SPREAD_DEPTH(depth),
    .O_SPREAD_TENTHS(tenths), .O_SPREAD_ACTIVE(sp_act), .O_SPREAD_WAVEFORM(wave),
    .O_MOD_RATE_SEL(rsel), .O_MOD_RATE_LOG2(rlog), .O_STEP_INVOKED(inv),
    .O_STEP_ACTIVE(st_act), .O_STEP_UP(up), .O_STEP_PERCENT(pct));
  // ====
  // bus tasks
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    `CHK("nv_req", a == 8'hF6, nv_req)
    `CHK("nv_data", (a == 8'hF6) ? (d & 8'hF7) : 8'h00, nv_wd)
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask
  // ====
  // decode check, expectation built from the field tables
  task automatic check_dec(input logic [7:0] v);
    logic [2:0] c;
    logic       s;
    logic       act;
    logic [3:0] rl;
    c = v[7:5];
    s = v[1:0] != 2'h0;
    act = (v[4] | pin) & !s & (c != 3'h7);
    rl = RATE_LOG2_EXP[{c, 2'h0} +: 4];
    `CHK("depth", v[1:0], depth)
    `CHK("active", s, sp_act)
    `CHK("tenths", s ? 8'h0F << (v[1:0] - 2'h1) : 8'h00, tenths)
    `CHK("wave", v[2] & s, wave)
    `CHK("invoked", v[4] | pin, inv)
    `CHK("step", act, st_act)
    `CHK("up", act & (c <= 3'h3), up)
    `CHK("pct", act ? ((c <= 3'h3) ? c + 3'h1 : c - 3'h3) : 3'h0, pct)
    `CHK("rsel", s ? ((c == 3'h7) ? 3'h6 : c) : 3'h0, rsel)
    `CHK("rlog", s ? rl : 4'h0, rlog)
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ====
  // scenarios
  task automatic run_reset_check();
    check_dec(8'h00);
    rd_reg(8'hF6, 8'h00);
  endtask
  // every code of every field, bit 3 must read back clear
  task automatic run_all_codes();
    for (int i = 0; i < 256; i++) begin
      wr_reg(8'hF6, i[7:0]);
      check_dec(i[7:0]);
      rd_reg(8'hF6, i[7:0] & 8'hF7);
    end
  endtask
  // writes elsewhere dropped, reads elsewhere answer zero
  task automatic run_unmapped();
    wr_reg(8'hF5, 8'h00);
    rd_reg(8'hF6, 8'hF7);
    rd_reg(8'hF5, 8'h00);
  endtask
  // recall alone, then recall colliding with a write and a read
  task automatic run_nv_load();
    @(posedge clk);
    nv_data <= 8'h68;
    nv_load <= 1'b1;
    @(posedge clk);
    nv_load <= 1'b0;
    #1;
    check_dec(8'h60);
    @(posedge clk);
    addr <= 8'hF6;
    wdata <= 8'h85;
    wr <= 1'b1;
    rd <= 1'b1;
    nv_data <= 8'h13;
    nv_load <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    nv_load <= 1'b0;
    #1;
    `CHK("rdata_old", 8'h60, rdata)
    `CHK("nv_req_hit", 1'b1, nv_req)
    check_dec(8'h85);
    rd_reg(8'hF6, 8'h85);
  endtask
  // pin crosses two stages, so the step shows three edges later
  task automatic run_step_pin();
    wr_reg(8'hF6, 8'hA0);
    @(posedge clk);
    pin <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_dec(8'hA0);
    wr_reg(8'hF6, 8'hA1);
    check_dec(8'hA1);
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    #50us;
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    run_reset_check();
    run_all_codes();
    run_unmapped();
    run_nv_load();
    run_step_pin();
    complete_run();
  end
endmodule
`default_nettype wire
